/* smi_misc_params.svh */
`ifndef SMI_MISC_PARAMS_SVH
`define SMI_MISC_PARAMS_SVH

// register indices; byte address is four times the index
`define IDX_SMI_GATE_FOUR    8'h19
`define IDX_SMI_GATE_FIVE    8'h1a
`define IDX_SMI_GATE_SIX     8'h1b
`define IDX_MISC_EDGE_STATUS 8'h1c
`define IDX_FORCE_DISK       8'h1e
`define IDX_FLOPPY_RATE      8'h1f
`define IDX_IRQ_STATUS_FOUR  8'h30
`define IDX_IRQ_STATUS_FIVE  8'h31
`define IDX_IRQ_STATUS_SIX   8'h32
`define IDX_IRQ_CLEAR_FOUR   8'h34
`define IDX_IRQ_CLEAR_FIVE   8'h35
`define IDX_IRQ_CLEAR_SIX    8'h36
`define IDX_PIN_CTRL         8'h38

// reset values
`define RST_SMI_GATE         8'h00
`define RST_MISC_EDGE        8'h00
`define RST_FORCE_DISK       8'h03
`define RST_FLOPPY_RATE      8'h02
`define RST_PIN_CTRL         8'h00

// field layouts
`define MISC_EDGE_MASK       8'h3f
`define FORCE_DISK_MASK      8'h03
`define FLOPPY_RATE_MASK     8'hdf
`define PIN_CTRL_MASK        8'h03
`define PIN_CTRL_ENABLE      0
`define PIN_CTRL_PUSH_PULL   1
`define FORCE_DRIVE0         0
`define FORCE_DRIVE1         1

// bus answers
`define RESP_OKAY            2'b00
`define RESP_DECERR          2'b11

// settle count reached after reset; pin filters report edges one cycle later
`define SYNC_SETTLE          2'd3

`endif

/* smi_misc_pkg.sv */
package smi_misc_pkg;

	// read channel sequencing
	typedef enum logic [0:0] {
		rd_idle = 1'b0,
		rd_data = 1'b1
	} rd_state_e;

	// one eight-bit register
	typedef logic [7:0] reg_byte_t;

endpackage

/* smi_enable_misc_status_regs.sv */
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "smi_misc_params.svh"

// Functional notes
// [R01] gate four routes pins 30-33,41,tach,43,61
// [R02] gate five routes pins 50-57 in order
// [R03] gate six routes pins 10-17 in order
// [R04] misc bits 0-5 set on either edge
// [R05] writing one clears misc bit, zero keeps
// [R06] misc bits 7:6 read zero
// [R07] software only sets force-change bits
// [R08] step with drive select clears force bit
// [R09] disk change flag combines selects, forces, input
// [R10] forced bit makes selected drive show change
// [R11] force bit0 drive 0, bit1 drive 1
// [R12] force bits 7:2 read zero
// [R13] read-only shadow mirrors floppy rate setting
// [R14] pin floats while pin enable is off
// [R15] irq is OR of enabled set status
// [R16] pin inputs synchronised before edge detection
module smi_enable_misc_status_regs
	import smi_misc_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	input  wire logic [6:0]        gp_group_four_in,
	input  wire logic              fan_speed_pulse_in,
	input  wire logic [7:0]        gp_group_five_in,
	input  wire logic [7:0]        gp_group_one_in,
	input  wire logic [5:0]        edge_pin_in,
	input  wire logic              head_step_strobe,
	input  wire logic              drive0_select,
	input  wire logic              drive1_select,
	input  wire logic              disk_change_input,
	input  wire logic [7:0]        floppy_rate_in,
	output logic                   disk_change_flag,
	output logic                   shared_mgmt_irq,
	output logic                   mgmt_irq_pin_out,
	output logic                   mgmt_irq_pin_oe
);

	localparam int PIN_W = 30;               // 24 gated sources plus 6 edge pins

	// word address to register index
	function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] a);
		reg_index = a[9:2];
	endfunction
	// true when an index names a register of this block
	function automatic logic is_mapped(input logic [7:0] idx);
		case (idx)
			`IDX_SMI_GATE_FOUR, `IDX_SMI_GATE_FIVE, `IDX_SMI_GATE_SIX,
			`IDX_MISC_EDGE_STATUS, `IDX_FORCE_DISK, `IDX_FLOPPY_RATE,
			`IDX_IRQ_STATUS_FOUR, `IDX_IRQ_STATUS_FIVE, `IDX_IRQ_STATUS_SIX,
			`IDX_IRQ_CLEAR_FOUR, `IDX_IRQ_CLEAR_FIVE, `IDX_IRQ_CLEAR_SIX,
			`IDX_PIN_CTRL: is_mapped = 1'b1;
			default: is_mapped = 1'b0;
		endcase
	endfunction

	// registers seen by software
	reg_byte_t          smi_gate_four;        // enables for the group-four sources
	reg_byte_t          smi_gate_five;        // enables for pins 50-57
	reg_byte_t          smi_gate_six;         // enables for pins 10-17
	reg_byte_t          misc_edge_status;     // either-edge flags, low six bits used
	reg_byte_t          force_disk_change;    // forced disk change per drive
	reg_byte_t          floppy_rate_shadow;   // copy of the floppy rate setting
	reg_byte_t          pin_ctrl;             // pin enable and buffer type
	logic [23:0]        irq_status;           // sticky source events, six:five:four
	// write channel holding state
	logic [ADDR_W-1:0]  awaddr_q;             // captured write address
	logic               aw_held;              // address waiting for its data
	logic [7:0]         wdata_q;              // low lane of captured data
	logic               wlane_q;              // low lane strobe captured
	logic               w_held;               // data waiting for its address
	logic               wr_fire;              // both halves present, commit now
	logic [7:0]         wr_idx;               // index of the committed write
	logic               wr_lane0;             // commit that touches the low lane
	// read channel state
	rd_state_e          rd_state;             // idle or presenting data
	// pin synchroniser and filter
	logic [PIN_W-1:0]   raw_pins;             // all asynchronous pin inputs
	logic [PIN_W-1:0]   sync1;                // first stage, read only by sync2
	logic [PIN_W-1:0]   sync2;                // second stage
	logic [PIN_W-1:0]   sync3;                // third stage
	logic [PIN_W-1:0]   filt;                 // accepted pin level
	logic [PIN_W-1:0]   pin_change;           // accepted change this cycle
	logic [PIN_W-1:0]   pin_rise;             // accepted rise this cycle
	logic [1:0]         settle_cnt;           // cycles since reset release
	logic               primed;               // filter trusted for edges
	// decoded clear effects of bus writes and head steps
	logic [23:0]        irq_clear;            // one-cycle clear of status bits
	logic [7:0]         misc_clear;           // one-cycle clear of misc flags
	logic [1:0]         force_hw_clear;       // step with select, per drive
	// register image returned on a read
	logic [31:0]        rd_word;
	logic [7:0]         rd_idx;

	// gather pins; bit 5 of the group-four slot is the tachometer
	assign raw_pins = {edge_pin_in, gp_group_one_in, gp_group_five_in,
		gp_group_four_in[6:5], fan_speed_pulse_in, gp_group_four_in[4:0]};

	// three-stage synchroniser on every pin input
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{sync1, sync2, sync3} <= '0;
		end else begin
			{sync3, sync2, sync1} <= {sync2, sync1, raw_pins}; // [R16]
		end
	end

	// hold edge reporting off until the stages carry real pin levels
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			settle_cnt <= 2'd0;
			primed     <= 1'b0;
		end else if (settle_cnt != `SYNC_SETTLE) begin
			settle_cnt <= settle_cnt + 2'd1;
		end else begin
			primed <= 1'b1;
		end
	end

	// a change counts only once stages two and three agree
	generate
		for (genvar gi = 0; gi < PIN_W; gi++) begin : g_filter
			assign pin_change[gi] = primed && (sync2[gi] == sync3[gi])
				&& (sync3[gi] != filt[gi]);                            // [R16]
			assign pin_rise[gi] = pin_change[gi] && sync3[gi];

			// accepted level; loaded directly while settling
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					filt[gi] <= 1'b0;
				end else if (!primed || (sync2[gi] == sync3[gi])) begin
					filt[gi] <= sync3[gi];
				end
			end
		end
	endgenerate

	// write address channel; ready drops on the taking edge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready  <= 1'b0;
			aw_held  <= 1'b0;
			awaddr_q <= '0;
		end else if (awvalid && awready) begin
			awready  <= 1'b0;
			aw_held  <= 1'b1;
			awaddr_q <= awaddr;
		end else if (wr_fire) begin
			aw_held <= 1'b0;
		end else if (!aw_held && !bvalid) begin
			awready <= 1'b1;
		end
	end

	// write data channel; only the low lane carries register bits
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wready  <= 1'b0;
			w_held  <= 1'b0;
			wdata_q <= 8'h00;
			wlane_q <= 1'b0;
		end else if (wvalid && wready) begin
			wready  <= 1'b0;
			w_held  <= 1'b1;
			wdata_q <= wdata[7:0];
			wlane_q <= wstrb[0];
		end else if (wr_fire) begin
			w_held <= 1'b0;
		end else if (!w_held && !bvalid) begin
			wready <= 1'b1;
		end
	end

	assign wr_fire  = aw_held && w_held && !bvalid;
	assign wr_idx   = reg_index(awaddr_q);
	assign wr_lane0 = wr_fire && wlane_q;
	// write response; unmapped addresses answer with a decode error
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp  <= `RESP_OKAY;
		end else if (wr_fire) begin
			bvalid <= 1'b1;
			bresp  <= is_mapped(wr_idx) ? `RESP_OKAY : `RESP_DECERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// plain read-write enables and pin control
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			smi_gate_four <= `RST_SMI_GATE;
			smi_gate_five <= `RST_SMI_GATE;
			smi_gate_six  <= `RST_SMI_GATE;
			pin_ctrl      <= `RST_PIN_CTRL;
		end else if (wr_lane0) begin
			case (wr_idx)
				`IDX_SMI_GATE_FOUR: smi_gate_four <= wdata_q;                // [R01]
				`IDX_SMI_GATE_FIVE: smi_gate_five <= wdata_q;                // [R02]
				`IDX_SMI_GATE_SIX:  smi_gate_six <= wdata_q;                 // [R03]
				`IDX_PIN_CTRL:      pin_ctrl <= wdata_q & `PIN_CTRL_MASK;
				default: ;
			endcase
		end
	end

	// clear strobes decoded from the committed write
	always_comb begin
		irq_clear  = 24'h000000;
		misc_clear = 8'h00;
		if (wr_lane0) begin
			case (wr_idx)
				`IDX_IRQ_CLEAR_FOUR:   irq_clear[7:0] = wdata_q;
				`IDX_IRQ_CLEAR_FIVE:   irq_clear[15:8] = wdata_q;
				`IDX_IRQ_CLEAR_SIX:    irq_clear[23:16] = wdata_q;
				`IDX_MISC_EDGE_STATUS: misc_clear = wdata_q & `MISC_EDGE_MASK; // [R05]
				default: ;
			endcase
		end
	end

	// sticky source status; a rise in the clearing cycle still sets
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_status <= 24'h000000;
		end else begin
			irq_status <= (irq_status & ~irq_clear) | pin_rise[23:0];
		end
	end

	// either-edge flags; set beats a simultaneous clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			misc_edge_status <= `RST_MISC_EDGE;
		end else begin
			misc_edge_status <= ((misc_edge_status & ~misc_clear)
				| {2'b00, pin_change[29:24]}) & `MISC_EDGE_MASK;     // [R04] [R06]
		end
	end

	// head step on a selected drive ends that drive's forced change
	assign force_hw_clear = {2{head_step_strobe}} & {drive1_select, drive0_select}; // [R08]
	// software may only set; a same-cycle software set outlives the step clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			force_disk_change <= `RST_FORCE_DISK;
		end else begin
			force_disk_change <= ((force_disk_change & ~{6'h00, force_hw_clear})
				| ((wr_lane0 && wr_idx == `IDX_FORCE_DISK) ? wdata_q : 8'h00))
				& `FORCE_DISK_MASK;                                   // [R07] [R11] [R12]
		end
	end

	// disk change seen by the floppy input register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			disk_change_flag <= 1'b0;
		end else begin
			disk_change_flag <= (drive0_select && force_disk_change[`FORCE_DRIVE0])
				|| (drive1_select && force_disk_change[`FORCE_DRIVE1])
				|| disk_change_input;                                  // [R09] [R10]
		end
	end

	// shadow copy; bus writes never reach it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			floppy_rate_shadow <= `RST_FLOPPY_RATE;
		end else begin
			floppy_rate_shadow <= floppy_rate_in & `FLOPPY_RATE_MASK;  // [R13]
		end
	end
	// interrupt is the OR of every enabled set status bit
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			shared_mgmt_irq <= 1'b0;
		end else begin
			shared_mgmt_irq <= |(irq_status
				& {smi_gate_six, smi_gate_five, smi_gate_four});       // [R15] [R01] [R02] [R03]
		end
	end
	// active-low pin; open drain only pulls while asserted
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mgmt_irq_pin_out <= 1'b1;
			mgmt_irq_pin_oe  <= 1'b0;
		end else begin
			mgmt_irq_pin_out <= !shared_mgmt_irq;
			mgmt_irq_pin_oe  <= pin_ctrl[`PIN_CTRL_ENABLE]
				&& (pin_ctrl[`PIN_CTRL_PUSH_PULL] || shared_mgmt_irq); // [R14]
		end
	end

	// read image; clear registers read as zero
	assign rd_idx = reg_index(araddr);
	always_comb begin
		rd_word = 32'h00000000;
		case (rd_idx)
			`IDX_SMI_GATE_FOUR:    rd_word[7:0] = smi_gate_four;
			`IDX_SMI_GATE_FIVE:    rd_word[7:0] = smi_gate_five;
			`IDX_SMI_GATE_SIX:     rd_word[7:0] = smi_gate_six;
			`IDX_MISC_EDGE_STATUS: rd_word[7:0] = misc_edge_status;   // [R06]
			`IDX_FORCE_DISK:       rd_word[7:0] = force_disk_change;  // [R12]
			`IDX_FLOPPY_RATE:      rd_word[7:0] = floppy_rate_shadow; // [R13]
			`IDX_IRQ_STATUS_FOUR:  rd_word[7:0] = irq_status[7:0];
			`IDX_IRQ_STATUS_FIVE:  rd_word[7:0] = irq_status[15:8];
			`IDX_IRQ_STATUS_SIX:   rd_word[7:0] = irq_status[23:16];
			`IDX_PIN_CTRL:         rd_word[7:0] = pin_ctrl;
			default:               rd_word = 32'h00000000;
		endcase
	end

	// read channel; data is captured on the address edge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_state <= rd_idle;
			arready  <= 1'b0;
			rvalid   <= 1'b0;
			rdata    <= 32'h00000000;
			rresp    <= `RESP_OKAY;
		end else begin
			case (rd_state)
				rd_idle: begin
					if (arvalid && arready) begin
						arready  <= 1'b0;
						rvalid   <= 1'b1;
						rdata    <= rd_word;
						rresp    <= is_mapped(rd_idx) ? `RESP_OKAY : `RESP_DECERR;
						rd_state <= rd_data;
					end else begin
						arready <= 1'b1;
					end
				end
				rd_data: begin
					// hold until the master takes it
					if (rready) begin
						rvalid   <= 1'b0;
						rd_state <= rd_idle;
					end
				end
				default: rd_state <= rd_idle;
			endcase
		end
	end

endmodule

/* smi_misc_props.sv */
`timescale 1ns/100ps
// watches bus answers, the floppy change flag and the interrupt pin
module smi_misc_props (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        awvalid,
	input wire logic        awready,
	input wire logic        wvalid,
	input wire logic        wready,
	input wire logic        bvalid,
	input wire logic        bready,
	input wire logic        arvalid,
	input wire logic        arready,
	input wire logic        rvalid,
	input wire logic        rready,
	input wire logic [31:0] rdata,
	input wire logic        drive0_select,
	input wire logic        drive1_select,
	input wire logic        disk_change_input,
	input wire logic        disk_change_flag,
	input wire logic        shared_mgmt_irq,
	input wire logic        mgmt_irq_pin_out,
	input wire logic        mgmt_irq_pin_oe
);
	// one clock domain, so clock and reset are set once
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// both halves of a write taken together: answer soon after
	AST_WR_ANSWER: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
		else $error("write not answered");
	AST_RD_ANSWER: assert property (arvalid && arready |=> rvalid)
		else $error("read not answered");
	// registers are a byte wide, upper lanes stay quiet
	AST_RD_TOP: assert property (rvalid |-> rdata[31:8] == 24'h0)
		else $error("upper read data not zero");
	AST_FLAG_RAW: assert property (disk_change_input |=> disk_change_flag)
		else $error("raw disk change not shown");
	// no select means forcing cannot act
	AST_FLAG_QUIET: assert property (
		!disk_change_input && !drive0_select && !drive1_select |=> !disk_change_flag)
		else $error("disk change flag without cause");
	AST_PIN_DRIVE: assert property (shared_mgmt_irq |=> !mgmt_irq_pin_out)
		else $error("pin not low while irq");
	AST_PIN_IDLE: assert property (!shared_mgmt_irq |=> mgmt_irq_pin_out || !mgmt_irq_pin_oe)
		else $error("pin driven low without irq");
	// gates and pin control reset to zero, so nothing can be routed or driven yet
	AST_IRQ_RESET: assert property ($rose(aresetn) |-> !shared_mgmt_irq [*4])
		else $error("irq right after reset");
	AST_OE_RESET: assert property ($rose(aresetn) |-> !mgmt_irq_pin_oe [*4])
		else $error("pin driven right after reset");

	COV_WRITE: cover property (bvalid && bready);
	COV_READ: cover property (rvalid && rready);
	COV_IRQ: cover property ($rose(shared_mgmt_irq));
endmodule

/* smi_enable_misc_status_regs_tb.sv */
`timescale 1ns/100ps
`include "smi_misc_params.svh"
module smi_enable_misc_status_regs_tb
	import smi_misc_pkg::*;
;
	logic        aclk = 1'b0;               // bus clock
	logic        aresetn = 1'b0;            // held low at start
	logic [11:0] awaddr = '0;
	logic        awvalid = 1'b0;
	logic [31:0] wdata = '0;
	logic [3:0]  wstrb = 4'hf;              // all lanes, only low byte counts
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic [11:0] araddr = '0;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic [6:0]  gp_group_four_in;
	logic        fan_speed_pulse_in;
	logic [7:0]  gp_group_five_in, gp_group_one_in;
	logic [5:0]  edge_pin_in = '0;
	logic        head_step_strobe = 1'b0;
	logic        drive0_select = 1'b0;
	logic        drive1_select = 1'b0;
	logic        disk_change_input = 1'b0;
	logic [7:0]  floppy_rate_in = 8'h02;    // matches the shadow default
	logic        disk_change_flag, shared_mgmt_irq, mgmt_irq_pin_out, mgmt_irq_pin_oe;
	reg_byte_t   src [3] = '{default: 8'h00}; // gated pins in gate-bit layout
	reg_byte_t   idx_tab [6] = '{`IDX_SMI_GATE_FOUR, `IDX_SMI_GATE_FIVE, `IDX_SMI_GATE_SIX,
		`IDX_MISC_EDGE_STATUS, `IDX_FORCE_DISK, `IDX_FLOPPY_RATE};
	reg_byte_t   rst_tab [6] = '{`RST_SMI_GATE, `RST_SMI_GATE, `RST_SMI_GATE,
		`RST_MISC_EDGE, `RST_FORCE_DISK, `RST_FLOPPY_RATE};
	int          fail_count = 0;
	int          check_count = 0;
	int          k;
	logic [31:0] seed = 32'h6ad7;           // fixed start, repeatable run
	logic [5:0]  m, c;
	reg_byte_t   b;

	// gate four holds the tachometer at bit 5 between the pins
	assign gp_group_four_in   = {src[0][7:6], src[0][4:0]};
	assign fan_speed_pulse_in = src[0][5];
	assign gp_group_five_in   = src[1];
	assign gp_group_one_in    = src[2];

	smi_enable_misc_status_regs u_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
		.wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready, .gp_group_four_in, .fan_speed_pulse_in, .gp_group_five_in,
		.gp_group_one_in, .edge_pin_in, .head_step_strobe, .drive0_select, .drive1_select,
		.disk_change_input, .floppy_rate_in, .disk_change_flag, .shared_mgmt_irq,
		.mgmt_irq_pin_out, .mgmt_irq_pin_oe);

	// free-running clock, 50 ns period
	always #25 aclk = ~aclk;

	// pseudo-random source
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
	endtask

	// one bus transfer; payloads held until their own ready
	task automatic xfer(input bit w, input reg_byte_t i, input reg_byte_t d,
		input logic [1:0] er);
		int n;
		bit got;
		got = 1'b0;
		if (w) begin
			awaddr  <= {2'b00, i, 2'b00};
			wdata   <= {24'h0, d};
			awvalid <= 1'b1;
			wvalid  <= 1'b1;
			bready  <= 1'b1;
		end else begin
			araddr  <= {2'b00, i, 2'b00};
			arvalid <= 1'b1;
			rready  <= 1'b1;
		end
		for (n = 0; n < 40 && !got; n++) begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (arready) arvalid <= 1'b0;
			if (bvalid && bready) begin
				got = 1'b1;
				bready <= 1'b0;
				chk(32'(bresp), 32'(er));
			end
			if (rvalid && rready) begin
				got = 1'b1;
				rready <= 1'b0;
				chk(rdata, {24'h0, d});
				chk(32'(rresp), 32'(er));
			end
		end
		// no answer at all counts as a mismatch
		if (!got) chk(32'h0, 32'h1);
		@(posedge aclk);
	endtask

	task automatic stop_test;
		if (fail_count == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// watchdog, well beyond the expected run
	initial begin
		tick(6000);
		$display("[FAIL] %0t watchdog expired", $time);
		fail_count++;
		stop_test();
	end

	// main sequence
	initial begin
		tick(10);
		aresetn <= 1'b1;
		tick(8);
		for (k = 0; k < 6; k++) xfer(0, idx_tab[k], rst_tab[k], `RESP_OKAY);
		for (k = 0; k < 3; k++) begin
			seed = lfsr(seed);
			xfer(1, idx_tab[k], seed[7:0], `RESP_OKAY);
			xfer(0, idx_tab[k], seed[7:0], `RESP_OKAY);
		end
		// unmapped place refused both ways
		xfer(1, 8'h40, 8'h55, `RESP_DECERR);
		xfer(0, 8'h40, 8'h00, `RESP_DECERR);
		// shadow follows input, ignores writes
		seed = lfsr(seed);
		floppy_rate_in <= seed[15:8];
		xfer(1, `IDX_FLOPPY_RATE, ~seed[15:8], `RESP_OKAY);
		xfer(0, `IDX_FLOPPY_RATE, seed[15:8] & `FLOPPY_RATE_MASK, `RESP_OKAY);
		// misc flags: rise, partial clear, then fall
		m = seed[21:16] | 6'h01;
		// low bit always in the clear, so the clear path is always exercised
		c = seed[5:0] | 6'h01;
		edge_pin_in <= m;
		tick(10);
		xfer(0, `IDX_MISC_EDGE_STATUS, {2'b00, m}, `RESP_OKAY);
		xfer(1, `IDX_MISC_EDGE_STATUS, {2'b11, c}, `RESP_OKAY);
		tick(10);
		xfer(0, `IDX_MISC_EDGE_STATUS, {2'b00, m & ~c}, `RESP_OKAY);
		edge_pin_in <= 6'h00;
		tick(10);
		xfer(0, `IDX_MISC_EDGE_STATUS, {2'b00, m}, `RESP_OKAY);
		// force bits: software cannot clear, step with select can
		xfer(1, `IDX_FORCE_DISK, 8'h00, `RESP_OKAY);
		xfer(0, `IDX_FORCE_DISK, 8'h03, `RESP_OKAY);
		drive1_select <= 1'b1;
		tick(3);
		chk(32'(disk_change_flag), 32'h1);
		drive1_select <= 1'b0;
		drive0_select <= 1'b1;
		head_step_strobe <= 1'b1;
		tick(1);
		head_step_strobe <= 1'b0;
		tick(3);
		chk(32'(disk_change_flag), 32'h0);
		xfer(0, `IDX_FORCE_DISK, 8'h02, `RESP_OKAY);
		disk_change_input <= 1'b1;
		tick(3);
		chk(32'(disk_change_flag), 32'h1);
		disk_change_input <= 1'b0;
		drive0_select <= 1'b0;
		xfer(1, `IDX_FORCE_DISK, 8'hff, `RESP_OKAY);
		xfer(0, `IDX_FORCE_DISK, 8'h03, `RESP_OKAY);
		// each gate: masked, routed, cleared; the middle one runs the pin open drain
		for (k = 0; k < 3; k++) begin
			seed = lfsr(seed);
			b = 8'h01 << seed[2:0];
			xfer(1, `IDX_PIN_CTRL, (k == 1) ? 8'h01 : 8'h03, `RESP_OKAY);
			xfer(1, idx_tab[k], 8'h00, `RESP_OKAY);
			src[k] <= b;
			tick(10);
			xfer(0, 8'(8'h30 + k), b, `RESP_OKAY);
			chk(32'(shared_mgmt_irq), 32'h0);
			xfer(1, idx_tab[k], b, `RESP_OKAY);
			tick(2);
			chk({29'h0, shared_mgmt_irq, mgmt_irq_pin_oe, mgmt_irq_pin_out}, 32'h6);
			xfer(1, 8'(8'h34 + k), b, `RESP_OKAY);
			tick(2);
			// open drain lets go once the irq drops, push-pull keeps driving high
			chk({30'h0, shared_mgmt_irq, mgmt_irq_pin_oe}, (k == 1) ? 32'h0 : 32'h1);
			src[k] <= 8'h00;
		end
		// pin enable off leaves the pin floating
		xfer(1, `IDX_PIN_CTRL, 8'h00, `RESP_OKAY);
		tick(2);
		chk(32'(mgmt_irq_pin_oe), 32'h0);
		stop_test();
	end
endmodule

bind smi_enable_misc_status_regs smi_misc_props u_props (.aclk, .aresetn, .awvalid, .awready,
	.wvalid, .wready, .bvalid, .bready, .arvalid, .arready, .rvalid, .rready, .rdata,
	.drive0_select, .drive1_select, .disk_change_input, .disk_change_flag, .shared_mgmt_irq,
	.mgmt_irq_pin_out, .mgmt_irq_pin_oe);
